// [rtl/isar_pkg.sv]
// package: register map, field positions and state type of the event flag / adc readback block
package isar_pkg;

	// ****************************************************************
	// register offsets (byte addresses)
	// ****************************************************************
	localparam logic [7:0] ISAR_OFS_ENABLE = 8'h08;
	localparam logic [7:0] ISAR_OFS_STATUS = 8'h0C;
	localparam logic [7:0] ISAR_OFS_DATA0  = 8'h10;
	localparam logic [7:0] ISAR_OFS_DATAN  = 8'h4C;
	localparam logic [7:0] ISAR_OFS_CLEAR  = 8'h60;
	localparam logic [7:0] ISAR_OFS_CALST  = 8'h64;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int ISAR_DMA_COUNT  = 4;
	localparam int ISAR_DMA_BASE   = 8;
	localparam int ISAR_DMA_STRIDE = 4;
	localparam int ISAR_POS_LOAD   = 0;
	localparam int ISAR_POS_FILL   = 1;
	localparam int ISAR_POS_EOL    = 2;
	localparam int ISAR_BIT_I2C    = 4;
	localparam int ISAR_BIT_BOARD  = 2;
	localparam int ISAR_PAIRS      = 16;
	localparam int ISAR_CHANNELS   = 32;

	// implemented flag bits; every other status bit is reserved
	localparam logic [31:0] ISAR_FLAG_MASK = 32'h0077_7714;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [31:0] ISAR_RST_FLAGS  = 32'h0000_0000;
	localparam logic [31:0] ISAR_RST_ENABLE = 32'h0000_0000;
	localparam logic [31:0] ISAR_RST_PAIR   = 32'h0000_0000;
	localparam logic [15:0] ISAR_RST_HALF   = 16'h0000;

	// ****************************************************************
	// state of the block
	// ****************************************************************
	typedef struct packed {
		logic [31:0]       flags;
		logic [31:0]       enable;
		logic [15:0][31:0] pairs;
		logic [31:0][15:0] shadow;
		logic              calValid;
		logic [31:0]       rdata;
		logic              ready;
		logic              slvErr;
		logic              irq;
	} isar_state_type;

endpackage : isar_pkg

// [rtl/isar_regs.sv]
// module: apb register bank with module event flags and adc channel pair readback
`timescale 1ns/100ps
module isar_regs
	import isar_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  dmaEolEvt,
	input  wire logic [3:0]  dmaMemFillEvt,
	input  wire logic [3:0]  dmaDescLoadEvt,
	input  wire logic        i2cOpDoneEvt,
	input  wire logic        boardCtrlIrqEvt,
	input  wire logic        calActive,
	input  wire logic        calDoneOk,
	input  wire logic        sampleValid,
	input  wire logic [4:0]  sampleChan,
	input  wire logic [13:0] sampleData,
	input  wire logic        sampleWide,
	output logic             irqOut
);

	// ****************************************************************
	// functions
	// ****************************************************************

	// true when the address hits one of the channel pair registers
	function automatic logic isPairAddr(input logic [7:0] addr);
		logic hit;
		hit = (addr >= ISAR_OFS_DATA0) && (addr <= ISAR_OFS_DATAN) && (addr[1:0] == 2'h0);
		return hit;
	endfunction : isPairAddr

	// pair index from a byte address inside the data window
	function automatic logic [3:0] pairIndex(input logic [7:0] addr);
		logic [7:0] rel;
		rel = addr - ISAR_OFS_DATA0;
		return rel[5:2];
	endfunction : pairIndex

	// msb alignment; a 12 bit sample sits in the low 12 bits of the port
	function automatic logic [15:0] alignSample(
		input logic [13:0] data,
		input logic        wide
	);
		logic [15:0] res;
		if (wide) begin
			res = {data, 2'h0};
		end else begin
			res = {data[11:0], 4'h0};
		end
		return res;
	endfunction : alignSample

	// ****************************************************************
	// state registers
	// ****************************************************************
	isar_state_type state_r;
	isar_state_type state_nxt;

	logic        access;
	logic        wrAccess;
	logic        clrHit;
	logic [31:0] clrMask;
	logic [31:0] evtVec;
	logic [3:0]  rdIdx;

	// an access completes at the edge where the master sees pready high
	assign access   = psel & penable & state_r.ready;
	assign wrAccess = access & pwrite;
	assign clrHit   = wrAccess & ((paddr == ISAR_OFS_STATUS) | (paddr == ISAR_OFS_CLEAR));
	assign clrMask  = clrHit ? (pwdata & ISAR_FLAG_MASK) : 32'h0000_0000;
	assign rdIdx    = pairIndex(paddr);

	// gather event strobes into the status layout
	always_comb begin
		evtVec = 32'h0000_0000;
		for (int k = 0; k < ISAR_DMA_COUNT; k++) begin
			evtVec[ISAR_DMA_BASE + ISAR_DMA_STRIDE*k + ISAR_POS_EOL]  = dmaEolEvt[k];
			evtVec[ISAR_DMA_BASE + ISAR_DMA_STRIDE*k + ISAR_POS_FILL] = dmaMemFillEvt[k];
			evtVec[ISAR_DMA_BASE + ISAR_DMA_STRIDE*k + ISAR_POS_LOAD] = dmaDescLoadEvt[k];
		end
		evtVec[ISAR_BIT_I2C]   = i2cOpDoneEvt;
		evtVec[ISAR_BIT_BOARD] = boardCtrlIrqEvt;
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		state_nxt = state_r;

		// flags: clear first, then set, so a coincident event survives
		state_nxt.flags = ((state_r.flags & ~clrMask) | evtVec) & ISAR_FLAG_MASK;

		// enable register steers the interrupt output only
		if (wrAccess && (paddr == ISAR_OFS_ENABLE)) begin
			state_nxt.enable = pwdata & ISAR_FLAG_MASK;
		end

		// samples land in the shadow only while calibration runs
		if (calActive && sampleValid) begin
			state_nxt.shadow[sampleChan] = alignSample(sampleData, sampleWide);
		end

		// a successful calibration publishes the shadow to the bus view
		if (calDoneOk) begin
			for (int p = 0; p < ISAR_PAIRS; p++) begin
				state_nxt.pairs[p] = {state_r.shadow[2*p + 1], state_r.shadow[2*p]};
			end
			state_nxt.calValid = 1'b1;
		end

		// one wait state: pready rises in the second access cycle
		state_nxt.ready  = psel & penable & ~state_r.ready;
		state_nxt.slvErr = 1'b0;
		state_nxt.rdata  = 32'h0000_0000;
		if (psel && penable && !state_r.ready) begin
			if (paddr == ISAR_OFS_ENABLE) begin
				state_nxt.rdata = state_r.enable;
			end else if (paddr == ISAR_OFS_STATUS) begin
				state_nxt.rdata = state_r.flags & ISAR_FLAG_MASK;
			end else if (paddr == ISAR_OFS_CLEAR) begin
				state_nxt.rdata = 32'h0000_0000;
			end else if (paddr == ISAR_OFS_CALST) begin
				state_nxt.rdata = {31'h0, state_r.calValid};
			end else if (isPairAddr(paddr)) begin
				state_nxt.rdata = state_r.pairs[rdIdx];
			end else begin
				// unmapped word: error response, data zero
				state_nxt.slvErr = 1'b1;
			end
			// pair registers are read-only; a write there is an error
			if (pwrite && isPairAddr(paddr)) begin
				state_nxt.slvErr = 1'b1;
			end
		end

		// interrupt from next values so irqOut tracks the flags exactly
		state_nxt.irq = |(state_nxt.flags & state_nxt.enable);
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_r.flags    <= ISAR_RST_FLAGS;
			state_r.enable   <= ISAR_RST_ENABLE;
			state_r.pairs    <= {ISAR_PAIRS{ISAR_RST_PAIR}};
			state_r.shadow   <= {ISAR_CHANNELS{ISAR_RST_HALF}};
			state_r.calValid <= 1'b0;
			state_r.rdata    <= 32'h0000_0000;
			state_r.ready    <= 1'b0;
			state_r.slvErr   <= 1'b0;
			state_r.irq      <= 1'b0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// outputs straight from the state flops
	assign prdata  = state_r.rdata;
	assign pready  = state_r.ready;
	assign pslverr = state_r.slvErr;
	assign irqOut  = state_r.irq;

endmodule : isar_regs

// [test/isar_regs_monitor.sv]
// checker: apb handshake, flag register and interrupt relations of the register bank
`timescale 1ns/100ps
module isar_regs_monitor
	import isar_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        srst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irqOut
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// outputs come out of reset quiet
	a_reset_quiet: assert property ($past(srst) |-> !pready && !irqOut && prdata == 32'h0)
		else $error("outputs busy after reset");
	a_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("answer not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_data_ro: assert property (psel && penable && !pready && pwrite &&
		paddr inside {[8'h10:8'h4C]} |=> pslverr)
		else $error("write to pair register not refused");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_idle_zero: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	a_status_rsvd: assert property (pready && !pwrite && paddr == ISAR_OFS_STATUS |->
		(prdata & ~ISAR_FLAG_MASK) == 32'h0) else $error("reserved status bit set");
	// an interrupt only drops after software wrote a clear or an enable
	a_irq_drop: assert property ($fell(irqOut) |-> $past(pready && pwrite))
		else $error("interrupt dropped without a write");
endmodule : isar_regs_monitor
bind isar_regs isar_regs_monitor mon_u (.ref_clk(ref_clk), .srst(srst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .irqOut(irqOut));

// [test/irq_status_adc_readback_tb.sv]
// testbench: event flags, interrupt and adc pair readback over apb
`timescale 1ns/100ps
module irq_status_adc_readback_tb;
	import isar_pkg::*;
	logic        ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic        i2cOpDoneEvt = 0, boardCtrlIrqEvt = 0, calActive = 0, calDoneOk = 0;
	logic        sampleValid = 0, sampleWide = 0, irqOut;
	logic [3:0]  dmaEolEvt = 0, dmaMemFillEvt = 0, dmaDescLoadEvt = 0;
	logic [4:0]  sampleChan = 0;
	logic [7:0]  paddr = 0;
	logic [13:0] sampleData = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	int          errorCnt = 0, checked = 0;
	always #2.5 ref_clk = ~ref_clk;
	isar_regs dut_u (
		.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dmaEolEvt(dmaEolEvt), .dmaMemFillEvt(dmaMemFillEvt), .dmaDescLoadEvt(dmaDescLoadEvt),
		.i2cOpDoneEvt(i2cOpDoneEvt), .boardCtrlIrqEvt(boardCtrlIrqEvt), .calActive(calActive),
		.calDoneOk(calDoneOk), .sampleValid(sampleValid), .sampleChan(sampleChan),
		.sampleData(sampleData), .sampleWide(sampleWide), .irqOut(irqOut)
	);
	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errorCnt++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : cmp
	// one apb transfer; request held until ready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
		@(posedge ref_clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		cmp({31'h0, pslverr}, {31'h0, err});
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, 1'b0);
		cmp(rd, exp);
	endtask : rdchk
	// drives the event input behind status bit b
	task automatic pulse(input int b, input logic v);
		if (b >= 8) case ((b - 8) % 4)
			0: dmaDescLoadEvt[(b - 8) / 4] <= v;
			1: dmaMemFillEvt[(b - 8) / 4] <= v;
			default: dmaEolEvt[(b - 8) / 4] <= v;
		endcase
		else if (b == 4) i2cOpDoneEvt <= v;
		else boardCtrlIrqEvt <= v;
	endtask : pulse
	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_flags;
		int bits[14] = '{8, 9, 10, 12, 13, 14, 16, 17, 18, 20, 21, 22, 4, 2};
		rdchk(ISAR_OFS_STATUS, 32'h0);
		apb(1'b1, ISAR_OFS_ENABLE, 32'hFFFF_FFFF, 1'b0);
		rdchk(ISAR_OFS_ENABLE, ISAR_FLAG_MASK);
		apb(1'b1, ISAR_OFS_ENABLE, 32'h0, 1'b0);
		foreach (bits[i]) begin
			@(posedge ref_clk);
			pulse(bits[i], 1'b1);
			@(posedge ref_clk);
			pulse(bits[i], 1'b0);
			rdchk(ISAR_OFS_STATUS, 32'h1 << bits[i]);
			cmp({31'h0, irqOut}, 32'h0);
			apb(1'b1, ISAR_OFS_ENABLE, 32'h1 << bits[i], 1'b0);
			repeat (2) @(posedge ref_clk);
			cmp({31'h0, irqOut}, 32'h1);
			// zeros on the flag and ones on reserved bits must change nothing
			apb(1'b1, ISAR_OFS_STATUS, ~(32'h1 << bits[i]), 1'b0);
			rdchk(ISAR_OFS_STATUS, 32'h1 << bits[i]);
			apb(1'b1, ISAR_OFS_STATUS, 32'h1 << bits[i], 1'b0);
			rdchk(ISAR_OFS_STATUS, 32'h0);
			cmp({31'h0, irqOut}, 32'h0);
		end
		$display("flags test done");
	endtask : t_flags
	// event lands on the very edge where the clear takes effect
	task automatic t_race;
		fork
			apb(1'b1, ISAR_OFS_STATUS, 32'h200, 1'b0);
			begin
				repeat (3) @(posedge ref_clk);
				pulse(9, 1'b1);
				@(posedge ref_clk);
				pulse(9, 1'b0);
			end
		join
		rdchk(ISAR_OFS_STATUS, 32'h200);
		// the separate clear word must drop the flag as well and read back zero
		apb(1'b1, ISAR_OFS_CLEAR, 32'h200, 1'b0);
		rdchk(ISAR_OFS_STATUS, 32'h0);
		rdchk(ISAR_OFS_CLEAR, 32'h0);
		$display("race test done");
	endtask : t_race
	task automatic t_adc;
		logic [31:0] exp[16];
		logic [13:0] d;
		calActive <= 1'b1;
		for (int c = 0; c < 32; c++) begin
			d = 14'(c * 517 + 3);
			@(posedge ref_clk);
			sampleValid <= 1'b1;
			sampleChan  <= 5'(c);
			sampleWide  <= c[0];
			sampleData  <= d;
			exp[c / 2][c[0] * 16 +: 16] = c[0] ? {d, 2'b00} : {d[11:0], 4'h0};
		end
		@(posedge ref_clk);
		sampleValid <= 1'b0;
		sampleChan  <= 5'h0;
		sampleData  <= 14'h3FFF;
		rdchk(ISAR_OFS_DATA0, 32'h0);
		rdchk(ISAR_OFS_CALST, 32'h0);
		apb(1'b1, ISAR_OFS_DATA0, 32'hFFFF_FFFF, 1'b1);
		apb(1'b0, 8'h50, 32'h0, 1'b1);
		calDoneOk <= 1'b1;
		calActive <= 1'b0;
		@(posedge ref_clk);
		calDoneOk <= 1'b0;
		for (int n = 0; n < 16; n++)
			rdchk(8'(ISAR_OFS_DATA0 + 4 * n), exp[n]);
		rdchk(ISAR_OFS_CALST, 32'h1);
		// a sample outside calibration is dropped; a second run replaces channel 1 only
		@(posedge ref_clk);
		sampleValid <= 1'b1;
		sampleChan  <= 5'h2;
		sampleWide  <= 1'b0;
		sampleData  <= 14'h2AAA;
		@(posedge ref_clk);
		calActive   <= 1'b1;
		sampleChan  <= 5'h1;
		sampleWide  <= 1'b1;
		sampleData  <= 14'h1555;
		@(posedge ref_clk);
		sampleValid <= 1'b0;
		calActive   <= 1'b0;
		calDoneOk   <= 1'b1;
		@(posedge ref_clk);
		calDoneOk   <= 1'b0;
		exp[0][31:16] = {14'h1555, 2'b00};
		rdchk(ISAR_OFS_DATA0, exp[0]);
		rdchk(8'(ISAR_OFS_DATA0 + 4), exp[1]);
		$display("adc test done");
	endtask : t_adc
	task automatic conclude;
		$display("checked %0d mismatches %0d", checked, errorCnt);
		if (errorCnt == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : conclude
	// watchdog: the run needs some 560 cycles
	initial begin
		#50us;
		errorCnt++;
		conclude();
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		srst <= 1'b0;
		t_flags();
		t_race();
		t_adc();
		conclude();
	end
endmodule : irq_status_adc_readback_tb
